/* shared/mirq_params.svh */
// Named offsets, field positions, reset values and counts of the interrupt request block.
`ifndef MIRQ_PARAMS_SVH
`define MIRQ_PARAMS_SVH

// ****************************************************************
// Register byte offsets on the bus
// ****************************************************************
`define MIRQ_OFF_EDGE 8'h00
`define MIRQ_OFF_PRI 8'h04
`define MIRQ_OFF_SEC 8'h08
`define MIRQ_OFF_GRPA 8'h0c
`define MIRQ_OFF_GRPB 8'h10
`define MIRQ_ADDR_W 8

// ****************************************************************
// Reset values and implemented-bit masks
// ****************************************************************
`define MIRQ_RST_BYTE 8'h00
`define MIRQ_EDGE_MASK 8'h0f
`define MIRQ_PRI_MASK 8'h7f
`define MIRQ_SEC_MASK 8'h77
`define MIRQ_GRPB_MASK0 8'h11
`define MIRQ_GRPB_MASK1 8'h33
`define MIRQ_GRPB_MASK2 8'h77

// ****************************************************************
// Field positions
// ****************************************************************
`define MIRQ_EDGE_P0_LO 0
`define MIRQ_EDGE_P0_HI 1
`define MIRQ_EDGE_P1_LO 2
`define MIRQ_EDGE_P1_HI 3
`define MIRQ_PRI_EMI 0
`define MIRQ_PRI_P0E 1
`define MIRQ_PRI_P1E 2
`define MIRQ_PRI_T0E 3
`define MIRQ_PRI_P0F 4
`define MIRQ_PRI_P1F 5
`define MIRQ_PRI_T0F 6
`define MIRQ_SEC_T1E 0
`define MIRQ_SEC_SME 1
`define MIRQ_SEC_MFE 2
`define MIRQ_SEC_T1F 4
`define MIRQ_SEC_SMF 5
`define MIRQ_SEC_MFF 6
`define MIRQ_GA_TBE 2
`define MIRQ_GA_ADF 4
`define MIRQ_GA_TBF 6
`define MIRQ_FLAG_LO 4
`define MIRQ_FLAG_HI 7
`define MIRQ_EN_LO 0
`define MIRQ_EN_HI 3

// ****************************************************************
// Source indices in priority order and their vectors
// ****************************************************************
`define MIRQ_SRC_P0 3'h0
`define MIRQ_SRC_P1 3'h1
`define MIRQ_SRC_T0 3'h2
`define MIRQ_SRC_T1 3'h3
`define MIRQ_SRC_SM 3'h4
`define MIRQ_SRC_GRP 3'h5
`define MIRQ_NUM_SRC 6
`define MIRQ_VEC_P0 8'h04
`define MIRQ_VEC_P1 8'h08
`define MIRQ_VEC_T0 8'h0c
`define MIRQ_VEC_T1 8'h10
`define MIRQ_VEC_SM 8'h14
`define MIRQ_VEC_GRP 8'h18

// ****************************************************************
// Timing
// ****************************************************************
`define MIRQ_INSTR_DIV 4
`define MIRQ_DIV_W 4

`endif

/* shared/mirq_pkg.sv */
// Types shared by the interrupt request block.
package mirq_pkg;
  // Edge selector codes of an external pin.
  typedef enum logic [1:0]
  {
    EDGE_OFF = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } mirq_edge_t;

  // Service handshake towards the core.
  typedef enum logic [0:0]
  {
    SRV_IDLE = 1'b0,
    SRV_REQ = 1'b1
  } mirq_srv_t;

  // Vector address and source index.
  typedef logic [7:0] mirq_vec_t;
  typedef logic [2:0] mirq_src_t;
endpackage

/* hdl/mirq_edge_det.sv */
// Synchronised edge detector for one external interrupt pin.
`timescale 1ns/1ps
module mirq_edge_det
  import mirq_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Pin and selection.
  input wire logic pin,
  input wire logic [1:0] sel,
  input wire logic arm,
  // Detected edge, one cycle.
  output logic hit
);
  // ****************************************************************
  // Synchroniser and history
  // ****************************************************************
  logic meta_q; // First stage, read only by the second stage.
  logic sync_q; // Second stage, safe to use.
  logic prev_q; // Previous synchronised level.
  logic hit_q; // Registered hit.

  // Two flops bring the pin into the clock domain before any logic reads it.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Low selector bit enables rising edges, high bit falling; code zero is off.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      hit_q <= 1'b0;
    else
      hit_q <= arm & (((sync_q & ~prev_q) & sel[0]) | ((~sync_q & prev_q) & sel[1]));
  end

  assign hit = hit_q;
endmodule

/* hdl/mirq_prio_enc.sv */
// Fixed-priority encoder: lowest index wins.
`timescale 1ns/1ps
module mirq_prio_enc
#(
  parameter int N = 6
)
(
  // Requests, bit zero highest priority.
  input wire logic [N-1:0] req,
  // Winner.
  output logic [2:0] idx,
  output logic any
);
  // Scan from lowest priority up so the highest one overwrites.
  always_comb
  begin
    idx = 3'h0;
    any = 1'b0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        idx = i[2:0];
        any = 1'b1;
      end
    end
  end

  generate
    if (N > 8 || N < 1)
    begin : g_bad_n
      $error("mirq_prio_enc supports one to eight requests");
    end
  endgenerate
endmodule

/* hdl/mirq_core.sv */
// Interrupt request, flag and enable logic with an AHB-Lite register slave.
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "mirq_params.svh"

// What this block does
// - Pin interrupt needs global, pin enable, edge code
// - Edge code: off, rising, falling, both
// - Selected pin transition sets pin flag
// - Pin zero vectors 04H, pin one 08H
// - Pin service clears its flag and global
// - Pin works only enabled and set as input
// - Pull-high selection stays valid during interrupt use
// - No request taken while return stack full
// - Primary register holds global, enables, flags
// - Secondary register holds timer one, serial, group
// - Group register A holds four flags, enables
// - Group register B holds SPI, timer flags
// - Timer overflow sets flag, needs global, enable
// - Timer service clears its flag and global
// - Time base overflow sets flag, needs enables
// - Time base service clears its flag, global
// - Conversion done sets flag, group vector
// - Conversion service clears group flag, global only
// - Serial byte sets flag, needs three enables
// - Serial service clears group flag, global only
// - Fixed priority, group sources share 18H
// - Any member flag set sets group flag
// - Flags stay set until serviced or cleared
// - Request presented on instruction cycle boundary
module mirq_core
  import mirq_pkg::*;
#(
  parameter int EXTRA_TIMERS = 2,
  parameter int INSTR_DIV = `MIRQ_INSTR_DIV,
  parameter bit GROUP_EN_HIGH = 1'b1
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // External pins and port setup.
  input wire logic ext_irq_pin_zero,
  input wire logic ext_irq_pin_one,
  input wire logic port_a_dir_four,
  input wire logic port_a_dir_six,
  input wire logic [1:0] pullup_sel,
  output logic [1:0] pin_pullup_en,
  // Peripheral event pulses.
  input wire logic timer_zero_ovf,
  input wire logic timer_one_ovf,
  input wire logic timer_two_ovf,
  input wire logic timer_three_ovf,
  input wire logic timebase_ovf,
  input wire logic rtc_evt,
  input wire logic conv_done,
  input wire logic periph_pin_evt,
  input wire logic serial_byte_done,
  input wire logic spi_unit_done,
  // Core handshake.
  input wire logic stack_full,
  input wire logic irq_ack,
  output logic irq_req,
  output logic [7:0] irq_vector
);
  // ****************************************************************
  // Parameter checks and derived constants
  // ****************************************************************
  generate
    if (EXTRA_TIMERS < 0 || EXTRA_TIMERS > 2 || INSTR_DIV < 1 || INSTR_DIV > 15)
    begin : g_bad_param
      $error("mirq_core parameters out of range");
    end
  endgenerate

  // Implemented bits of group register B depend on the number of extra timers.
  localparam logic [7:0] GRPB_MASK = (EXTRA_TIMERS == 0) ? `MIRQ_GRPB_MASK0 :
                                     (EXTRA_TIMERS == 1) ? `MIRQ_GRPB_MASK1 : `MIRQ_GRPB_MASK2;
  localparam logic [`MIRQ_DIV_W-1:0] DIV_LAST = 4'(INSTR_DIV - 1);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0] edge_q; // Edge selectors.
  logic [7:0] pri_q; // Global, pin and timer zero controls.
  logic [7:0] sec_q; // Timer one, serial and group controls.
  logic [7:0] grpa_q; // Group member flags and enables.
  logic [7:0] grpb_q; // SPI and extra timer flags and enables.
  logic wr_pend_q; // Write data phase pending.
  logic rd_pend_q; // Read wait state pending.
  logic [`MIRQ_ADDR_W-1:0] addr_q; // Latched address.
  logic [31:0] hrdata_q; // Read data.
  logic hready_q; // Slave ready.
  logic hresp_q; // Always OKAY.
  logic [`MIRQ_DIV_W-1:0] div_q; // Instruction cycle divider.
  logic tick_q; // One pulse per instruction cycle.
  mirq_srv_t srv_q; // Service state.
  mirq_src_t src_q; // Source being serviced.
  logic req_q; // Request to the core.
  mirq_vec_t vec_q; // Vector to the core.
  logic [1:0] pull_q; // Pull-high enables.

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic addr_ok; // Address phase accepted.
  logic wr_edge, wr_pri, wr_sec, wr_grpa, wr_grpb; // Register write strobes.
  logic [7:0] wbyte; // Written byte.

  // Only NONSEQ or SEQ with the bus ready start a transfer; hsize is ignored, words only.
  assign addr_ok = hsel & htrans[1] & hready;
  assign wbyte = hwdata[7:0];
  assign wr_edge = wr_pend_q & (addr_q == `MIRQ_OFF_EDGE);
  assign wr_pri = wr_pend_q & (addr_q == `MIRQ_OFF_PRI);
  assign wr_sec = wr_pend_q & (addr_q == `MIRQ_OFF_SEC);
  assign wr_grpa = wr_pend_q & (addr_q == `MIRQ_OFF_GRPA);
  assign wr_grpb = wr_pend_q & (addr_q == `MIRQ_OFF_GRPB);

  // Reads take one wait state so that a read right behind a write sees the new value.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= '0;
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
    end
    else
    begin
      wr_pend_q <= addr_ok & hwrite;
      rd_pend_q <= addr_ok & ~hwrite;
      hready_q <= ~(addr_ok & ~hwrite);
      hresp_q <= 1'b0;
      if (addr_ok)
        addr_q <= haddr[`MIRQ_ADDR_W-1:0];
    end
  end

  // Read mux; unmapped addresses and unimplemented bits read as zero.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      hrdata_q <= '0;
    else if (rd_pend_q)
    begin
      unique case (addr_q)
        `MIRQ_OFF_EDGE: hrdata_q <= {24'h000000, edge_q};
        `MIRQ_OFF_PRI: hrdata_q <= {24'h000000, pri_q};
        `MIRQ_OFF_SEC: hrdata_q <= {24'h000000, sec_q};
        `MIRQ_OFF_GRPA: hrdata_q <= {24'h000000, grpa_q};
        `MIRQ_OFF_GRPB: hrdata_q <= {24'h000000, grpb_q};
        default: hrdata_q <= '0;
      endcase
    end
  end

  // ****************************************************************
  // Pin detection
  // ****************************************************************
  logic arm0, arm1; // Pin may raise a flag.
  logic hit0, hit1; // Detected edges.

  // A pin takes part only when enabled, set as input and its selector is not off.
  assign arm0 = pri_q[`MIRQ_PRI_P0E] & port_a_dir_four & (edge_q[1:0] != EDGE_OFF);
  assign arm1 = pri_q[`MIRQ_PRI_P1E] & port_a_dir_six & (edge_q[3:2] != EDGE_OFF);

  mirq_edge_det u_det0
  (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin(ext_irq_pin_zero),
    .sel(edge_q[`MIRQ_EDGE_P0_HI:`MIRQ_EDGE_P0_LO]),
    .arm(arm0),
    .hit(hit0)
  );

  mirq_edge_det u_det1
  (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin(ext_irq_pin_one),
    .sel(edge_q[`MIRQ_EDGE_P1_HI:`MIRQ_EDGE_P1_LO]),
    .arm(arm1),
    .hit(hit1)
  );

  // Pull-high choice passes through untouched by interrupt use.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      pull_q <= 2'b00;
    else
      pull_q <= pullup_sel;
  end

  // ****************************************************************
  // Sources and priority
  // ****************************************************************
  logic [3:0] ga_set; // Group A hardware sets.
  logic [3:0] gb_set; // Group B hardware sets, bit 3 unused.
  logic [3:0] ga_en, gb_en; // Group enables at active-high sense.
  logic grp_hit; // An enabled member flag is set.
  logic [`MIRQ_NUM_SRC-1:0] src_req; // Requests in priority order.
  mirq_src_t win_idx; // Winner.
  logic win_any; // Any winner.
  logic ack_fire; // Core acknowledges service.

  assign ga_set = {periph_pin_evt, timebase_ovf, rtc_evt, conv_done};
  assign gb_set = {1'b0, timer_three_ovf, timer_two_ovf, spi_unit_done} & GRPB_MASK[7:4];
  // The printed sub-enable sense is ambiguous, so it is a parameter.
  assign ga_en = GROUP_EN_HIGH ? grpa_q[3:0] : ~grpa_q[3:0];
  assign gb_en = (GROUP_EN_HIGH ? grpb_q[3:0] : ~grpb_q[3:0]) & GRPB_MASK[3:0];
  assign grp_hit = |(grpa_q[7:4] & ga_en) | |(grpb_q[7:4] & gb_en);
  assign src_req[`MIRQ_SRC_P0] = pri_q[`MIRQ_PRI_P0F] & pri_q[`MIRQ_PRI_P0E];
  assign src_req[`MIRQ_SRC_P1] = pri_q[`MIRQ_PRI_P1F] & pri_q[`MIRQ_PRI_P1E];
  assign src_req[`MIRQ_SRC_T0] = pri_q[`MIRQ_PRI_T0F] & pri_q[`MIRQ_PRI_T0E];
  assign src_req[`MIRQ_SRC_T1] = sec_q[`MIRQ_SEC_T1F] & sec_q[`MIRQ_SEC_T1E];
  assign src_req[`MIRQ_SRC_SM] = sec_q[`MIRQ_SEC_SMF] & sec_q[`MIRQ_SEC_SME] & sec_q[`MIRQ_SEC_MFE];
  assign src_req[`MIRQ_SRC_GRP] = sec_q[`MIRQ_SEC_MFF] & sec_q[`MIRQ_SEC_MFE] & grp_hit;
  assign ack_fire = (srv_q == SRV_REQ) & irq_ack;

  mirq_prio_enc #(.N(`MIRQ_NUM_SRC)) u_prio
  (
    .req(src_req),
    .idx(win_idx),
    .any(win_any)
  );

  // ****************************************************************
  // Flag and enable registers
  // ****************************************************************
  // Edge selectors: plain storage.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      edge_q <= `MIRQ_RST_BYTE;
    else if (wr_edge)
      edge_q <= wbyte & `MIRQ_EDGE_MASK;
  end

  // Later assignments win, so service beats software and hardware sets beat both.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      pri_q <= `MIRQ_RST_BYTE;
    else
    begin
      if (wr_pri)
        pri_q <= wbyte & `MIRQ_PRI_MASK;
      if (ack_fire)
      begin
        pri_q[`MIRQ_PRI_EMI] <= 1'b0;
        if (src_q == `MIRQ_SRC_P0)
          pri_q[`MIRQ_PRI_P0F] <= 1'b0;
        if (src_q == `MIRQ_SRC_P1)
          pri_q[`MIRQ_PRI_P1F] <= 1'b0;
        if (src_q == `MIRQ_SRC_T0)
          pri_q[`MIRQ_PRI_T0F] <= 1'b0;
      end
      if (hit0)
        pri_q[`MIRQ_PRI_P0F] <= 1'b1;
      if (hit1)
        pri_q[`MIRQ_PRI_P1F] <= 1'b1;
      if (timer_zero_ovf)
        pri_q[`MIRQ_PRI_T0F] <= 1'b1;
    end
  end

  // Serial service clears only the group flag; its own flag waits for software.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      sec_q <= `MIRQ_RST_BYTE;
    else
    begin
      if (wr_sec)
        sec_q <= wbyte & `MIRQ_SEC_MASK;
      if (ack_fire && src_q == `MIRQ_SRC_T1)
        sec_q[`MIRQ_SEC_T1F] <= 1'b0;
      if (ack_fire && (src_q == `MIRQ_SRC_SM || src_q == `MIRQ_SRC_GRP))
        sec_q[`MIRQ_SEC_MFF] <= 1'b0;
      if (timer_one_ovf)
        sec_q[`MIRQ_SEC_T1F] <= 1'b1;
      if (serial_byte_done)
        sec_q[`MIRQ_SEC_SMF] <= 1'b1;
      if (serial_byte_done || (|ga_set) || (|gb_set))
        sec_q[`MIRQ_SEC_MFF] <= 1'b1;
    end
  end

  // Group A flags stay set on service except time base, which clears itself.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      grpa_q <= `MIRQ_RST_BYTE;
    else
    begin
      if (wr_grpa)
        grpa_q <= wbyte;
      if (ack_fire && src_q == `MIRQ_SRC_GRP && ga_en[`MIRQ_GA_TBE])
        grpa_q[`MIRQ_GA_TBF] <= 1'b0;
      grpa_q[`MIRQ_FLAG_HI:`MIRQ_FLAG_LO] <= (wr_grpa ? wbyte[7:4] : grpa_q[7:4]) &
        ~((ack_fire && src_q == `MIRQ_SRC_GRP && ga_en[`MIRQ_GA_TBE]) ? 4'h4 : 4'h0) | ga_set;
    end
  end

  // Group B flags are only ever cleared by software.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      grpb_q <= `MIRQ_RST_BYTE;
    else
    begin
      if (wr_grpb)
        grpb_q <= wbyte & GRPB_MASK;
      grpb_q[`MIRQ_FLAG_HI:`MIRQ_FLAG_LO] <= ((wr_grpb ? wbyte[7:4] : grpb_q[7:4]) | gb_set) & GRPB_MASK[7:4];
    end
  end

  // ****************************************************************
  // Instruction cycle divider
  // ****************************************************************
  // Requests are sampled once per instruction cycle, like the core's own fetch slot.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q <= (div_q == DIV_LAST) ? '0 : div_q + 4'h1;
      tick_q <= (div_q == DIV_LAST);
    end
  end

  // ****************************************************************
  // Service sequencer
  // ****************************************************************
  // The request is held until the core acknowledges; a full stack blocks acceptance.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      srv_q <= SRV_IDLE;
      src_q <= `MIRQ_SRC_P0;
      req_q <= 1'b0;
      vec_q <= '0;
    end
    else
    begin
      unique case (srv_q)
        SRV_IDLE:
        begin
          if (tick_q && win_any && pri_q[`MIRQ_PRI_EMI] && !stack_full)
          begin
            srv_q <= SRV_REQ;
            src_q <= win_idx;
            req_q <= 1'b1;
            unique case (win_idx)
              `MIRQ_SRC_P0: vec_q <= `MIRQ_VEC_P0;
              `MIRQ_SRC_P1: vec_q <= `MIRQ_VEC_P1;
              `MIRQ_SRC_T0: vec_q <= `MIRQ_VEC_T0;
              `MIRQ_SRC_T1: vec_q <= `MIRQ_VEC_T1;
              `MIRQ_SRC_SM: vec_q <= `MIRQ_VEC_SM;
              default: vec_q <= `MIRQ_VEC_GRP;
            endcase
          end
        end
        SRV_REQ:
        begin
          if (irq_ack)
          begin
            srv_q <= SRV_IDLE;
            req_q <= 1'b0;
          end
        end
      endcase
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hready_q;
  assign hresp = hresp_q;
  assign pin_pullup_en = pull_q;
  assign irq_req = req_q;
  assign irq_vector = vec_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_ack_group;
    srv_q == SRV_REQ && irq_ack && src_q == `MIRQ_SRC_GRP && !wr_grpa && !conv_done;
  endsequence

  a_req_needs_emi: assert property ($rose(req_q) |-> $past(pri_q[`MIRQ_PRI_EMI]) && $past(tick_q))
    else $error("request raised without global enable");
  a_stack_blocks: assert property ($rose(req_q) |-> !$past(stack_full))
    else $error("request raised while stack full");
  a_ack_clears_emi: assert property (ack_fire && !hit0 |=> !pri_q[`MIRQ_PRI_EMI] && !req_q)
    else $error("service did not clear global enable");
  a_pin0_vector: assert property (req_q && src_q == `MIRQ_SRC_P0 |-> vec_q == `MIRQ_VEC_P0)
    else $error("pin zero vector wrong");
  a_pin0_flag_clr: assert property (ack_fire && src_q == `MIRQ_SRC_P0 && !hit0 |=> !pri_q[`MIRQ_PRI_P0F])
    else $error("pin zero flag not cleared on service");
  a_group_keeps_conv: assert property (s_ack_group |=> grpa_q[`MIRQ_GA_ADF] == $past(grpa_q[`MIRQ_GA_ADF]))
    else $error("conversion flag changed by service");
  a_set_beats_clr: assert property (timer_zero_ovf && wr_pri && !wbyte[`MIRQ_PRI_T0F] |=> pri_q[`MIRQ_PRI_T0F])
    else $error("hardware set lost to software clear");
  a_edge_off_quiet: assert property (edge_q[1:0] == EDGE_OFF [*4] |-> !hit0)
    else $error("disabled pin raised a hit");
  a_group_flag_set: assert property (conv_done |=> sec_q[`MIRQ_SEC_MFF])
    else $error("group flag not set by member");
  a_prio_pin0: assert property ($rose(req_q) && $past(src_req[`MIRQ_SRC_P0]) |-> src_q == `MIRQ_SRC_P0)
    else $error("pin zero lost priority");
  a_read_wait: assert property (addr_ok && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
endmodule

/* verification/mirq_core_model.sv */
// Core sequencer model that services interrupt requests.
`timescale 1ns/1ps
module mirq_core_model
#(
  parameter int LAT = 3
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Request in, service out.
  input wire logic irq_req,
  output logic irq_ack
);
  // Cycles waited before the vector is taken.
  logic [3:0] cnt_q;
  // Ack pulses once, only while a request stands, so a late drop is seen.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q <= 4'h0;
      irq_ack <= 1'b0;
    end
    else
    begin
      irq_ack <= irq_req && !irq_ack && cnt_q == LAT[3:0];
      cnt_q <= (irq_req && !irq_ack && cnt_q != LAT[3:0]) ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule

/* verification/mirq_core_bench.sv */
// Self-checking bench of the interrupt request block.
`timescale 1ns/1ps
`include "mirq_params.svh"
module mirq_core_bench
  import mirq_pkg::*;
;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic p0 = 1'b0;
  logic p1 = 1'b1;
  logic dir_four = 1'b0;
  logic dir_six = 1'b0;
  logic [1:0] pull_sel = 2'h0;
  logic [9:0] evt = 10'h0;
  logic stack_full = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq_req;
  logic irq_ack;
  logic [1:0] pull_en;
  logic [7:0] irq_vector;
  int errors = 0;
  int check_count = 0;
  // Free-running core clock.
  always #5 core_clk = ~core_clk;
  // The one slave drives the bus ready.
  mirq_core DUT (.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_irq_pin_zero(p0), .ext_irq_pin_one(p1),
    .port_a_dir_four(dir_four), .port_a_dir_six(dir_six), .pullup_sel(pull_sel), .pin_pullup_en(pull_en),
    .timer_zero_ovf(evt[0]), .timer_one_ovf(evt[1]), .timer_two_ovf(evt[2]), .timer_three_ovf(evt[3]),
    .timebase_ovf(evt[4]), .rtc_evt(evt[5]), .conv_done(evt[6]), .periph_pin_evt(evt[7]),
    .serial_byte_done(evt[8]), .spi_unit_done(evt[9]), .stack_full(stack_full), .irq_ack(irq_ack),
    .irq_req(irq_req), .irq_vector(irq_vector));
  mirq_core_model #(.LAT(3)) core (.core_clk(core_clk), .nrst(nrst), .irq_req(irq_req), .irq_ack(irq_ack));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // One single transfer; request held until ready is sampled high.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    chk(n, {24'h0, e}, r);
    chk("response", 32'h0, {31'h0, hresp});
  endtask
  // Pulses an event, or toggles a pin for indices ten and eleven.
  task automatic fire(input int i);
    @(posedge core_clk);
    if (i < 10)
      evt[i] <= 1'b1;
    else if (i == 10)
      p0 <= ~p0;
    else if (i == 11)
      p1 <= ~p1;
    @(posedge core_clk);
    evt <= 10'h0;
  endtask
  // Waits a bounded time for the request, then for its drop after service.
  task automatic take(input logic [7:0] vec);
    int n;
    n = 0;
    while (irq_req !== 1'b1 && n < 200)
    begin
      @(posedge core_clk);
      n++;
    end
    chk("request", 32'h1, {31'h0, irq_req});
    chk("vector", {24'h0, vec}, {24'h0, irq_vector});
    while (irq_req === 1'b1)
      @(posedge core_clk);
  endtask
  task automatic run_src(input int i, input logic [7:0] pri, sec, ga, vec, pa, sa, gaa);
    wr(`MIRQ_OFF_SEC, sec);
    wr(`MIRQ_OFF_GRPA, ga);
    wr(`MIRQ_OFF_PRI, pri);
    fire(i);
    take(vec);
    rdc("primary", `MIRQ_OFF_PRI, pa);
    rdc("secondary", `MIRQ_OFF_SEC, sa);
    rdc("group a", `MIRQ_OFF_GRPA, gaa);
    wr(`MIRQ_OFF_PRI, 8'h00);
    wr(`MIRQ_OFF_SEC, 8'h00);
    wr(`MIRQ_OFF_GRPA, 8'h00);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    for (int a = 0; a <= 16; a += 4)
      rdc("reset", a[7:0], 8'h00);
    wr(8'h14, 8'hff);
    rdc("unmapped", 8'h14, 8'h00);
    wr(`MIRQ_OFF_EDGE, 8'hff);
    rdc("edge", `MIRQ_OFF_EDGE, 8'h0f);
    wr(`MIRQ_OFF_GRPB, 8'hff);
    rdc("group b", `MIRQ_OFF_GRPB, 8'h77);
    wr(`MIRQ_OFF_SEC, 8'hff);
    rdc("secondary", `MIRQ_OFF_SEC, 8'h77);
    wr(`MIRQ_OFF_GRPA, 8'hff);
    rdc("group a", `MIRQ_OFF_GRPA, 8'hff);
    wr(`MIRQ_OFF_PRI, 8'hfe);
    rdc("primary", `MIRQ_OFF_PRI, 8'h7e);
    for (int a = 0; a <= 16; a += 4)
      wr(a[7:0], 8'h00);
    $display("test registers done");
  endtask
  // Timer, serial and group sources one at a time, and software-set flags of timer zero and one together: timer zero wins.
  task automatic t_sources;
    run_src(0, 8'h09, 8'h00, 8'h00, 8'h0c, 8'h08, 8'h00, 8'h00);
    run_src(1, 8'h01, 8'h01, 8'h00, 8'h10, 8'h00, 8'h01, 8'h00);
    run_src(8, 8'h01, 8'h06, 8'h00, 8'h14, 8'h00, 8'h26, 8'h00);
    run_src(6, 8'h01, 8'h04, 8'h01, 8'h18, 8'h00, 8'h04, 8'h11);
    run_src(4, 8'h01, 8'h04, 8'h04, 8'h18, 8'h00, 8'h04, 8'h04);
    run_src(5, 8'h01, 8'h04, 8'h02, 8'h18, 8'h00, 8'h04, 8'h22);
    run_src(7, 8'h01, 8'h04, 8'h08, 8'h18, 8'h00, 8'h04, 8'h88);
    run_src(12, 8'h49, 8'h11, 8'h00, 8'h0c, 8'h08, 8'h11, 8'h00);
    wr(`MIRQ_OFF_GRPB, 8'h01);
    run_src(9, 8'h01, 8'h04, 8'h00, 8'h18, 8'h00, 8'h04, 8'h00);
    rdc("spi flag", `MIRQ_OFF_GRPB, 8'h11);
    $display("test sources done");
  endtask
  // A full stack holds the request back; the flag waits.
  task automatic t_stack;
    stack_full <= 1'b1;
    wr(`MIRQ_OFF_PRI, 8'h09);
    fire(0);
    repeat (20) @(posedge core_clk);
    chk("held", 32'h0, {31'h0, irq_req});
    rdc("pending", `MIRQ_OFF_PRI, 8'h49);
    stack_full <= 1'b0;
    take(8'h0c);
    wr(`MIRQ_OFF_PRI, 8'h00);
    $display("test stack done");
  endtask
  task automatic t_pins;
    pull_sel <= 2'h3;
    dir_four <= 1'b1;
    dir_six <= 1'b1;
    wr(`MIRQ_OFF_EDGE, 8'h09);
    chk("pullup", 32'h3, {30'h0, pull_en});
    run_src(10, 8'h03, 8'h00, 8'h00, 8'h04, 8'h02, 8'h00, 8'h00);
    run_src(11, 8'h05, 8'h00, 8'h00, 8'h08, 8'h04, 8'h00, 8'h00);
    wr(`MIRQ_OFF_EDGE, 8'h00);
    wr(`MIRQ_OFF_PRI, 8'h03);
    fire(10);
    repeat (20) @(posedge core_clk);
    chk("off code", 32'h0, {31'h0, irq_req});
    rdc("no flag", `MIRQ_OFF_PRI, 8'h03);
    $display("test pins done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence after three cycles of reset.
  initial
  begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    t_regs;
    t_sources;
    t_stack;
    t_pins;
    end_sim;
  end
  // Watchdog well beyond the expected run.
  initial
  begin
    #300us;
    errors++;
    end_sim;
  end
endmodule
